/* File: src/chfl_cfg.svh */
// Offsets, field positions and reset values of the channel option block.
// Assumes byte addressing on a 32-bit register bus, one register per word.
`ifndef CHFL_CFG_SVH
`define CHFL_CFG_SVH

`define CHFL_ADDR_W 5
`define CHFL_OFF_CSEL 5'h00
`define CHFL_OFF_OPTS 5'h04
`define CHFL_OFF_SPEC 5'h08
`define CHFL_OFF_CTRL 5'h0C
`define CHFL_OFF_STAT 5'h10
`define CHFL_OFF_TXD 5'h14

`define CHFL_OPT_RESET 8'h00
`define CHFL_BIT_IXM 7
`define CHFL_BIT_INBAND 6
`define CHFL_BIT_ETC 5
`define CHFL_BIT_LLOOP 4
`define CHFL_BIT_RLOOP 3
`define CHFL_BIT_RTS_AUTO_OUTPUT_EN 2
`define CHFL_BIT_CTS_AUTO_GATE_EN 1
`define CHFL_BIT_DSR_AUTO_GATE_EN 0

`define CHFL_CTRL_XON2 0
`define CHFL_CTRL_XOFF2 1
`define CHFL_CTRL_TXEN 2
`define CHFL_CTRL_RXEN 3
`define CHFL_CTRL_CMD 4

`define CHFL_SPEC_RESET 32'h00000000
`define CHFL_RESP_OKAY 2'h0
`define CHFL_RESP_SLVERR 2'h2
`define CHFL_FIFO_DEPTH 8

`endif

/* File: src/chfl_pkg.sv */
// Types shared by the channel option block and its bench.
// Assumes the constants header is compiled alongside.
package chfl_pkg;
  typedef logic [7:0] chfl_byte_t;
  typedef logic [31:0] chfl_word_t;
  typedef enum {chfl_wr_collect, chfl_wr_resp} chfl_wr_e;
endpackage

/* File: src/chfl_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ns
module chfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wptr_next = push ? bump(wptr_reg) : wptr_reg;
    rptr_next = pop ? bump(rptr_reg) : rptr_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = CW'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = CW'(cnt_reg - 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end
endmodule

/* File: src/chfl_top.sv */
// Per-channel flow-control, loopback and modem-gating options behind AXI4-Lite.
// Assumes received characters arrive on the aclk domain; modem pins are asynchronous.
// How it works
// - Implied-Xon bit matters only while automatic in-band flow control is on.
// - Implied-Xon set: any received character other than Xoff restarts a channel halted by Xoff.
// - Implied-Xon clear: halted channel waits for the Xon character or pair.
// - On Xoff, the held character still goes out, then transmission stops.
// - Embedded transmit command bit enables embedded command interpretation downstream.
// - Local loopback bit takes effect on a control write with the command bit: one selects local loopback, zero returns to normal.
// - Remote loopback bit one selects remote loopback; zero disables it.
// - Auto RTS with channel enabled asserts RTS while characters wait to send.
// - Auto RTS plus auto CTS: transmitter waits for CTS before sending.
// - Auto CTS set: CTS input enables or disables the transmitter.
// - Auto DSR set: DSR input enables or disables the receiver.
// - Xon is character 1 or 1 then 3; Xoff is 2 or 2 then 4.
`include "chfl_cfg.svh"
`timescale 1ns/1ns
module chfl_top #(
  parameter int NCH = 4,
  parameter int FIFO_DEPTH = `CHFL_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CHFL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire chfl_pkg::chfl_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CHFL_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output chfl_pkg::chfl_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic [$clog2(NCH)-1:0] rx_chan,
  input wire chfl_pkg::chfl_byte_t rx_data,
  output logic [NCH-1:0] rx_out_valid,
  output logic [8*NCH-1:0] rx_out_data,
  output logic [NCH-1:0] tx_valid,
  input wire logic [NCH-1:0] tx_ready,
  output logic [8*NCH-1:0] tx_data,
  input wire logic [NCH-1:0] cts_n,
  input wire logic [NCH-1:0] dsr_n,
  output logic [NCH-1:0] rts_n,
  output logic [NCH-1:0] local_loopback_en,
  output logic [NCH-1:0] remote_loopback_en,
  output logic [NCH-1:0] embedded_tx_cmd_en
);
  import chfl_pkg::*;
  localparam int CW = $clog2(NCH);

  chfl_wr_e wst_reg, wst_next;
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [`CHFL_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  chfl_word_t w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic rvalid_reg, rvalid_next;
  chfl_word_t rdata_reg, rdata_next, spec_reg, spec_next;
  logic [CW-1:0] csel_reg, csel_next;
  chfl_byte_t opt_reg [NCH];
  chfl_byte_t opt_next [NCH];
  logic [3:0] ctrl_reg [NCH];
  logic [3:0] ctrl_next [NCH];
  logic [NCH-1:0] lloop_reg, lloop_next, halt_reg, halt_next;
  logic [NCH-1:0] pxon_reg, pxon_next, pxoff_reg, pxoff_next;
  logic [NCH-1:0] hold_v_reg, hold_v_next, rts_reg, rts_next;
  logic [NCH-1:0] rxo_v_reg, rxo_v_next;
  chfl_byte_t hold_d_reg [NCH];
  chfl_byte_t hold_d_next [NCH];
  chfl_byte_t rxo_d_reg [NCH];
  chfl_byte_t rxo_d_next [NCH];
  logic [NCH-1:0] cts_s1, cts_s2, cts_s3, cts_on_reg, cts_on_next;
  logic [NCH-1:0] dsr_s1, dsr_s2, dsr_s3, dsr_on_reg, dsr_on_next;
  logic [NCH-1:0] tx_gate, rx_gate, tx_fire, f_in_v, f_in_r, f_out_v, f_out_r;
  chfl_byte_t f_out_d [NCH];
  logic do_write, is_txd;

  function automatic chfl_byte_t spec_char(input chfl_word_t s, input int n);
    spec_char = s[8*(n-1) +: 8];
  endfunction

  function automatic logic lane0_write(input logic [3:0] strb);
    lane0_write = strb[0];
  endfunction

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      chfl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(f_in_v[g]),
        .in_ready(f_in_r[g]),
        .in_data(w_data_reg[7:0]),
        .out_valid(f_out_v[g]),
        .out_ready(f_out_r[g]),
        .out_data(f_out_d[g])
      );
      assign tx_data[8*g +: 8] = hold_d_reg[g];
      assign rx_out_data[8*g +: 8] = rxo_d_reg[g];
    end
  endgenerate

  // Modem inputs: three stages, level taken once stages two and three agree
  always_comb begin
    cts_on_next = cts_on_reg;
    dsr_on_next = dsr_on_reg;
    for (int i = 0; i < NCH; i++) begin
      if (cts_s2[i] == cts_s3[i]) begin
        cts_on_next[i] = !cts_s3[i];
      end
      if (dsr_s2[i] == dsr_s3[i]) begin
        dsr_on_next[i] = !dsr_s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cts_s1, cts_s2, cts_s3, dsr_s1, dsr_s2, dsr_s3} <= '1;
      cts_on_reg <= '0;
      dsr_on_reg <= '0;
    end else begin
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
      dsr_s1 <= dsr_n;
      dsr_s2 <= dsr_s1;
      dsr_s3 <= dsr_s2;
      cts_on_reg <= cts_on_next;
      dsr_on_reg <= dsr_on_next;
    end
  end

  // Bus handshakes
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = (wst_reg == chfl_wr_resp);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign is_txd = (aw_addr_reg == `CHFL_OFF_TXD);
  assign do_write = aw_hold_reg && w_hold_reg && (wst_reg == chfl_wr_collect)
                    && !(is_txd && !f_in_r[csel_reg]);

  // Per-channel gating and transmit path
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      tx_gate[i] = ctrl_reg[i][`CHFL_CTRL_TXEN]
                   && (!opt_reg[i][`CHFL_BIT_CTS_AUTO_GATE_EN] || cts_on_reg[i]);
      rx_gate[i] = ctrl_reg[i][`CHFL_CTRL_RXEN]
                   && (!opt_reg[i][`CHFL_BIT_DSR_AUTO_GATE_EN] || dsr_on_reg[i]);
      tx_valid[i] = hold_v_reg[i] && tx_gate[i] && !lloop_reg[i];
      tx_fire[i] = hold_v_reg[i] && tx_gate[i] && (lloop_reg[i] || tx_ready[i]);
      f_out_r[i] = (!hold_v_reg[i] || tx_fire[i]) && !halt_reg[i];
      f_in_v[i] = do_write && is_txd && lane0_write(w_strb_reg) && (csel_reg == CW'(i));
      remote_loopback_en[i] = opt_reg[i][`CHFL_BIT_RLOOP];
      embedded_tx_cmd_en[i] = opt_reg[i][`CHFL_BIT_ETC];
    end
  end
  assign rts_n = ~rts_reg;
  assign rx_out_valid = rxo_v_reg;
  assign local_loopback_en = lloop_reg;

  // Character path, flow control and register state
  always_comb begin
    chfl_byte_t c;
    logic hit, xon_hit, xoff_hit, inband;
    c = '0;
    hit = 1'b0;
    xon_hit = 1'b0;
    xoff_hit = 1'b0;
    inband = 1'b0;
    halt_next = halt_reg;
    pxon_next = pxon_reg;
    pxoff_next = pxoff_reg;
    hold_v_next = hold_v_reg;
    hold_d_next = hold_d_reg;
    rxo_v_next = '0;
    rxo_d_next = rxo_d_reg;
    rts_next = rts_reg;
    lloop_next = lloop_reg;
    for (int i = 0; i < NCH; i++) begin
      if (f_out_r[i] && f_out_v[i]) begin
        hold_v_next[i] = 1'b1;
        hold_d_next[i] = f_out_d[i];
      end else if (tx_fire[i]) begin
        hold_v_next[i] = 1'b0;
      end
      rts_next[i] = opt_reg[i][`CHFL_BIT_RTS_AUTO_OUTPUT_EN] && ctrl_reg[i][`CHFL_CTRL_TXEN]
                    && (hold_v_reg[i] || f_out_v[i]);
      if (lloop_reg[i]) begin
        hit = tx_fire[i] && rx_gate[i];
        c = hold_d_reg[i];
      end else begin
        hit = rx_valid && (rx_chan == CW'(i)) && rx_gate[i];
        c = rx_data;
      end
      inband = opt_reg[i][`CHFL_BIT_INBAND];
      xon_hit = ctrl_reg[i][`CHFL_CTRL_XON2] ? (pxon_reg[i] && c == spec_char(spec_reg, 3))
                : (c == spec_char(spec_reg, 1));
      xoff_hit = ctrl_reg[i][`CHFL_CTRL_XOFF2] ? (pxoff_reg[i] && c == spec_char(spec_reg, 4))
                 : (c == spec_char(spec_reg, 2));
      if (hit) begin
        rxo_v_next[i] = 1'b1;
        rxo_d_next[i] = c;
        pxon_next[i] = ctrl_reg[i][`CHFL_CTRL_XON2] && (c == spec_char(spec_reg, 1));
        pxoff_next[i] = ctrl_reg[i][`CHFL_CTRL_XOFF2] && (c == spec_char(spec_reg, 2));
        if (inband && xoff_hit) begin
          halt_next[i] = 1'b1;
        end else if (inband && halt_reg[i] && opt_reg[i][`CHFL_BIT_IXM]) begin
          halt_next[i] = 1'b0;
        end else if (inband && xon_hit) begin
          halt_next[i] = 1'b0;
        end
      end
      if (!inband) begin
        halt_next[i] = 1'b0;
      end
    end
    if (do_write && aw_addr_reg == `CHFL_OFF_CTRL && lane0_write(w_strb_reg)
        && w_data_reg[`CHFL_CTRL_CMD]) begin
      lloop_next[csel_reg] = opt_reg[csel_reg][`CHFL_BIT_LLOOP];
    end
  end

  // Bus slave and software registers
  always_comb begin
    wst_next = wst_reg;
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    csel_next = csel_reg;
    spec_next = spec_reg;
    opt_next = opt_reg;
    ctrl_next = ctrl_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    case (wst_reg)
      chfl_wr_collect: begin
        if (do_write) begin
          wst_next = chfl_wr_resp;
          aw_hold_next = 1'b0;
          w_hold_next = 1'b0;
          bresp_next = `CHFL_RESP_OKAY;
          if (aw_addr_reg == `CHFL_OFF_CSEL) begin
            if (lane0_write(w_strb_reg)) csel_next = w_data_reg[CW-1:0];
          end else if (aw_addr_reg == `CHFL_OFF_OPTS) begin
            if (lane0_write(w_strb_reg)) opt_next[csel_reg] = w_data_reg[7:0];
          end else if (aw_addr_reg == `CHFL_OFF_SPEC) begin
            for (int b = 0; b < 4; b++) begin
              if (w_strb_reg[b]) spec_next[8*b +: 8] = w_data_reg[8*b +: 8];
            end
          end else if (aw_addr_reg == `CHFL_OFF_CTRL) begin
            if (lane0_write(w_strb_reg)) ctrl_next[csel_reg] = w_data_reg[3:0];
          end else if (!is_txd) begin
            bresp_next = `CHFL_RESP_SLVERR;
          end
        end
      end
      chfl_wr_resp: begin
        if (s_axi_bready) wst_next = chfl_wr_collect;
      end
      default: wst_next = chfl_wr_collect;
    endcase
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `CHFL_RESP_OKAY;
      rdata_next = '0;
      if (s_axi_araddr == `CHFL_OFF_CSEL) begin
        rdata_next[CW-1:0] = csel_reg;
      end else if (s_axi_araddr == `CHFL_OFF_OPTS) begin
        rdata_next[7:0] = opt_reg[csel_reg];
      end else if (s_axi_araddr == `CHFL_OFF_SPEC) begin
        rdata_next = spec_reg;
      end else if (s_axi_araddr == `CHFL_OFF_CTRL) begin
        rdata_next[3:0] = ctrl_reg[csel_reg];
      end else if (s_axi_araddr == `CHFL_OFF_STAT) begin
        rdata_next[5:0] = {dsr_on_reg[csel_reg], cts_on_reg[csel_reg], rx_gate[csel_reg],
                           tx_gate[csel_reg], lloop_reg[csel_reg], halt_reg[csel_reg]};
      end else begin
        rresp_next = `CHFL_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= chfl_wr_collect;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bresp_reg <= `CHFL_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `CHFL_RESP_OKAY;
      csel_reg <= '0;
      spec_reg <= `CHFL_SPEC_RESET;
      for (int i = 0; i < NCH; i++) begin
        opt_reg[i] <= `CHFL_OPT_RESET;
        ctrl_reg[i] <= '0;
        hold_d_reg[i] <= '0;
        rxo_d_reg[i] <= '0;
      end
      {lloop_reg, halt_reg, pxon_reg, pxoff_reg} <= '0;
      {hold_v_reg, rts_reg, rxo_v_reg} <= '0;
    end else begin
      wst_reg <= wst_next;
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      csel_reg <= csel_next;
      spec_reg <= spec_next;
      opt_reg <= opt_next;
      ctrl_reg <= ctrl_next;
      hold_d_reg <= hold_d_next;
      rxo_d_reg <= rxo_d_next;
      lloop_reg <= lloop_next;
      halt_reg <= halt_next;
      pxon_reg <= pxon_next;
      pxoff_reg <= pxoff_next;
      hold_v_reg <= hold_v_next;
      rts_reg <= rts_next;
      rxo_v_reg <= rxo_v_next;
    end
  end
endmodule

/* File: testbench/chfl_assertions.sv */
// Checker for the channel option block, watching its top-level ports only.
// Assumes the constants header and the package are compiled first.
`include "chfl_cfg.svh"
`timescale 1ns/1ns
module chfl_assertions #(parameter int NCH = 4) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CHFL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire chfl_pkg::chfl_word_t s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rx_valid,
  input wire logic [$clog2(NCH)-1:0] rx_chan,
  input wire chfl_pkg::chfl_byte_t rx_data,
  input wire logic [NCH-1:0] rx_out_valid,
  input wire logic [8*NCH-1:0] rx_out_data,
  input wire logic [NCH-1:0] tx_valid,
  input wire logic [NCH-1:0] tx_ready,
  input wire logic [8*NCH-1:0] tx_data,
  input wire logic [NCH-1:0] local_loopback_en
);
  import chfl_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_loop_no_tx;
    local_loopback_en[0] |-> !tx_valid[0];
  endproperty
  a_loop_no_tx: assert property (p_loop_no_tx) else $error("tx_valid in local loopback");
  property p_tx_hold;
    tx_valid[0] && !tx_ready[0] |=> $stable(tx_data[7:0]);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("held tx character changed");
  property p_rx_route;
    rx_out_valid[1] |-> $past(rx_valid && rx_chan == 1) || $past(local_loopback_en[1]);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx on wrong channel");
  property p_rx_data;
    rx_out_valid[0] && !$past(local_loopback_en[0]) |-> rx_out_data[7:0] == $past(rx_data);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx data differs from line");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read response dropped");
  property p_ar_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > `CHFL_OFF_TXD
      |=> s_axi_rresp == `CHFL_RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule
bind chfl_top chfl_assertions #(.NCH(NCH)) chfl_assertions_i (.*);

/* File: testbench/chfl_line_model.sv */
// Line-side partner: remote terminal sending characters and taking tx data.
// Assumes the bench calls send_char and sets stall, slow and the modem levels.
`timescale 1ns/1ns
module chfl_line_model #(parameter int NCH = 4) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCH-1:0] tx_valid,
  input wire logic [8*NCH-1:0] tx_data,
  output logic [NCH-1:0] tx_ready,
  output logic rx_valid,
  output logic [$clog2(NCH)-1:0] rx_chan,
  output logic [7:0] rx_data,
  output logic [NCH-1:0] cts_n,
  output logic [NCH-1:0] dsr_n
);
  logic stall = '0;
  logic slow = '0;
  logic [15:0] s = 16'hACE1;
  logic [7:0] got[$];
  initial begin
    tx_ready = '0;
    rx_valid = '0;
    rx_chan = '0;
    rx_data = 8'hFF;
    cts_n = '1;
    dsr_n = '1;
  end
  // Takes channel 0 characters, stalling or answering slowly on request
  always @(posedge aclk) begin
    s <= {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    if (aresetn && tx_valid[0] && tx_ready[0]) got.push_back(tx_data[7:0]);
    tx_ready <= {NCH{!stall && (!slow || s[0])}};
  end
  // One received character; the data line then shows the inverse
  task automatic send_char(input logic [7:0] c);
    rx_valid <= '1;
    rx_chan <= '0;
    rx_data <= c;
    @(posedge aclk);
    rx_valid <= '0;
    rx_chan <= '1;
    rx_data <= ~c;
    @(posedge aclk);
  endtask
endmodule

/* File: testbench/tb.sv */
// Bench for the channel option block: registers, flow control, loopback, gating.
// Assumes the design, the line model and the checker are compiled before it.
`include "chfl_cfg.svh"
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module tb;
  import chfl_pkg::*;
  localparam int NCH = 4;
  logic aclk = '0;
  logic aresetn;
  logic [`CHFL_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  chfl_word_t s_axi_wdata, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_chan;
  chfl_byte_t rx_data;
  logic [NCH-1:0] rx_out_valid, tx_valid, tx_ready, cts_n, dsr_n, rts_n;
  logic [NCH-1:0] local_loopback_en, remote_loopback_en, embedded_tx_cmd_en;
  logic [8*NCH-1:0] rx_out_data, tx_data;
  int n_fail = 0, n_checks = 0, cyc = 0;
  logic [15:0] seed = 16'h7A60;
  chfl_byte_t exq[$], rxq[$];
  chfl_top #(.NCH(NCH), .FIFO_DEPTH(`CHFL_FIFO_DEPTH)) chfl_top_i (.*);
  chfl_line_model #(.NCH(NCH)) chfl_line_model_i (.*);
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && rx_out_valid[0]) rxq.push_back(rx_out_data[7:0]);
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic rnd(output chfl_byte_t b);
    seed = lfsr(seed);
    b = seed[7:0];
  endtask
  task automatic wr(input logic [4:0] a, input chfl_word_t d, input logic [1:0] er);
    logic aw, w;
    aw = '1;
    w = '1;
    s_axi_awaddr <= a;
    s_axi_awprot <= seed[2:0];
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge aclk);
      if (aw && s_axi_awready) s_axi_awvalid <= '0;
      if (aw && s_axi_awready) aw = '0;
      if (w && s_axi_wready) s_axi_wvalid <= '0;
      if (w && s_axi_wready) w = '0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
    s_axi_bready <= '0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [4:0] a, input chfl_word_t e, input logic [1:0] er);
    logic ar;
    ar = '1;
    s_axi_araddr <= a;
    s_axi_arprot <= seed[6:4];
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do begin
      @(posedge aclk);
      if (ar && s_axi_arready) s_axi_arvalid <= '0;
      if (ar && s_axi_arready) ar = '0;
    end while (!s_axi_rvalid);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
    s_axi_rready <= '0;
    @(posedge aclk);
  endtask
  task automatic opt(input chfl_word_t d);
    wr(`CHFL_OFF_OPTS, d, `CHFL_RESP_OKAY);
  endtask
  task automatic push(input int n);
    chfl_byte_t b;
    repeat (n) begin
      rnd(b);
      exq.push_back(b);
      wr(`CHFL_OFF_TXD, {24'h0, b}, `CHFL_RESP_OKAY);
    end
  endtask
  task automatic qchk(ref logic [7:0] q[$], input int n);
    chfl_byte_t b, e;
    for (int k = 0; k < 300 && q.size() < n; k++) @(posedge aclk);
    repeat (20) @(posedge aclk);
    `CHK(q.size(), n)
    while (q.size() > 0 && exq.size() > 0) begin
      b = q.pop_front();
      e = exq.pop_front();
      `CHK(b, e)
    end
  endtask
  task automatic xoff_then(input int n, input chfl_word_t o);
    opt(o);
    chfl_line_model_i.stall <= '1;
    push(n);
    chfl_line_model_i.send_char(8'h13);
  endtask
  initial begin
    chfl_byte_t v[NCH];
    aresetn <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    rdc(`CHFL_OFF_OPTS, 32'h0, `CHFL_RESP_OKAY);
    for (int i = 0; i < NCH; i++) begin
      rnd(v[i]);
      wr(`CHFL_OFF_CSEL, i, `CHFL_RESP_OKAY);
      opt({24'hFFFFFF, v[i]});
    end
    for (int i = 0; i < NCH; i++) begin
      wr(`CHFL_OFF_CSEL, i, `CHFL_RESP_OKAY);
      rdc(`CHFL_OFF_OPTS, {24'h0, v[i]}, `CHFL_RESP_OKAY);
      `CHK(remote_loopback_en[i], v[i][3])
      `CHK(embedded_tx_cmd_en[i], v[i][5])
      `CHK(local_loopback_en[i], 1'h0)
      opt(32'h0);
    end
    rdc(5'h18, 32'h0, `CHFL_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    opt(32'hFF);
    s_axi_wstrb <= 4'hF;
    rdc(`CHFL_OFF_OPTS, 32'h0, `CHFL_RESP_OKAY);
    wr(5'h1C, 32'h1, `CHFL_RESP_SLVERR);
    wr(`CHFL_OFF_SPEC, 32'hA4A31311, `CHFL_RESP_OKAY);
    wr(`CHFL_OFF_CSEL, 32'h0, `CHFL_RESP_OKAY);
    wr(`CHFL_OFF_CTRL, 32'h0C, `CHFL_RESP_OKAY);
    xoff_then(3, 32'h40);
    rdc(`CHFL_OFF_STAT, 32'h0D, `CHFL_RESP_OKAY);
    chfl_line_model_i.stall <= '0;
    qchk(chfl_line_model_i.got, 1);
    chfl_line_model_i.send_char(8'h55);
    qchk(chfl_line_model_i.got, 0);
    chfl_line_model_i.send_char(8'h11);
    qchk(chfl_line_model_i.got, 2);
    xoff_then(2, 32'hC0);
    chfl_line_model_i.stall <= '0;
    qchk(chfl_line_model_i.got, 1);
    chfl_line_model_i.send_char(8'h5A);
    qchk(chfl_line_model_i.got, 1);
    xoff_then(2, 32'h80);
    chfl_line_model_i.stall <= '0;
    qchk(chfl_line_model_i.got, 2);
    wr(`CHFL_OFF_CTRL, 32'h0F, `CHFL_RESP_OKAY);
    chfl_line_model_i.slow <= '1;
    xoff_then(3, 32'h40);
    chfl_line_model_i.send_char(8'h55);
    chfl_line_model_i.stall <= '0;
    qchk(chfl_line_model_i.got, 3);
    xoff_then(3, 32'h40);
    chfl_line_model_i.send_char(8'hA4);
    chfl_line_model_i.stall <= '0;
    qchk(chfl_line_model_i.got, 1);
    chfl_line_model_i.send_char(8'h11);
    qchk(chfl_line_model_i.got, 0);
    chfl_line_model_i.send_char(8'h11);
    chfl_line_model_i.send_char(8'hA3);
    qchk(chfl_line_model_i.got, 2);
    wr(`CHFL_OFF_CTRL, 32'h0C, `CHFL_RESP_OKAY);
    opt(32'h06);
    push(`CHFL_FIFO_DEPTH + 1);
    `CHK(rts_n[0], 1'h0)
    `CHK(rts_n[1], 1'h1)
    `CHK(tx_valid[0], 1'h0)
    chfl_line_model_i.cts_n[0] <= '0;
    qchk(chfl_line_model_i.got, `CHFL_FIFO_DEPTH + 1);
    `CHK(rts_n[0], 1'h1)
    opt(32'h10);
    `CHK(local_loopback_en[0], 1'h0)
    wr(`CHFL_OFF_CTRL, 32'h1C, `CHFL_RESP_OKAY);
    `CHK(local_loopback_en[0], 1'h1)
    rxq.delete();
    push(2);
    qchk(rxq, 2);
    `CHK(chfl_line_model_i.got.size(), 0)
    chfl_line_model_i.send_char(8'h5A);
    qchk(rxq, 0);
    opt(32'h01);
    wr(`CHFL_OFF_CTRL, 32'h1C, `CHFL_RESP_OKAY);
    `CHK(local_loopback_en[0], 1'h0)
    chfl_line_model_i.send_char(8'h4B);
    qchk(rxq, 0);
    chfl_line_model_i.dsr_n[0] <= '0;
    repeat (6) @(posedge aclk);
    exq.push_back(8'h4C);
    chfl_line_model_i.send_char(8'h4C);
    qchk(rxq, 1);
    end_of_test();
  end
endmodule
